// ===== hdl/exp_trig_pkg.sv
// exposure trigger control: shared constants, register map and types
// assumes a 20 MHz system clock and a 32-bit classic wishbone slave port
package exp_trig_pkg;

	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned US_PER_S      = 1_000_000;
	localparam int unsigned CYC_PER_US    = CLK_HZ / US_PER_S;

	localparam logic [31:0] SHUTTER_MIN_US = 32'h0000_0004;
	localparam logic [31:0] SHUTTER_MAX_US = 32'h0393_8700;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_SHUTTER = 8'h04;
	localparam logic [7:0] OFS_OFFSET  = 8'h08;
	localparam logic [7:0] OFS_DELAY   = 8'h0C;
	localparam logic [7:0] OFS_CMD     = 8'h10;
	localparam logic [7:0] OFS_STATUS  = 8'h14;
	localparam logic [7:0] OFS_FRPER   = 8'h18;
	localparam logic [7:0] OFS_READOUT = 8'h1C;

	// control and command register fields
	localparam int unsigned CTRL_TRIG_ON   = 0;
	localparam int unsigned CTRL_FALLING   = 1;
	localparam int unsigned CTRL_PULSE     = 2;
	localparam int unsigned CTRL_SRC_LSB   = 4;
	localparam int unsigned CTRL_DLY_SRC   = 7;
	localparam int unsigned CMD_RUN        = 0;
	localparam int unsigned CMD_HALT       = 1;
	localparam int unsigned CMD_SOFT_TRIG  = 2;

	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
	localparam logic [31:0] SHUTTER_RESET  = 32'h0000_2710;
	localparam logic [31:0] FRPER_RESET    = 32'h0000_C350;
	localparam logic [31:0] READOUT_RESET  = 32'h0000_03E8;
	localparam logic [31:0] BAD_ADDR_DATA  = 32'h0000_0000;

	typedef enum logic [2:0]
	{
		SRC_SOFTWARE = 3'b000,
		SRC_USER_OUT = 3'b001,
		SRC_LINK     = 3'b010,
		SRC_DELAY    = 3'b011,
		SRC_LINE     = 3'b100
	} trig_src_t;

	typedef enum logic [1:0]
	{
		EXP_WAIT  = 2'b00,
		EXP_TIMED = 2'b01,
		EXP_PULSE = 2'b10
	} exp_state_t;

	typedef struct packed
	{
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed
	{
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

endpackage

// ===== hdl/exposure_trigger_control.sv
// exposure trigger control: start source selection, edge detect, delay,
// duration timing, overlap with readout and the shutter-open output
// assumes synchronous inputs on clk_i and a classic wishbone master
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module exposure_trigger_control
(
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire exp_trig_pkg::wb_req_t    wb_req_i,
	output var  exp_trig_pkg::wb_rsp_t    wb_rsp_o,
	input  wire logic                     hardware_input_line_i,
	input  wire logic                     host_link_strobe_i,
	input  wire logic                     user_driven_output_bit_i,
	output logic                          shutter_open_o,
	output logic                          readout_busy_o,
	output logic                          frame_start_o
);
	import exp_trig_pkg::*;

	logic [31:0] ctrl_reg;
	logic [31:0] shutter_reg;
	logic [31:0] offset_reg;
	logic [31:0] delay_reg;
	logic [31:0] frper_reg;
	logic [31:0] readout_reg;
	logic        running_reg;
	logic        soft_trig_reg;
	logic        ack_reg;
	logic [31:0] rdat_reg;
	logic [31:0] frames_reg;

	logic [2:0]  line_sync_reg;
	logic [2:0]  link_sync_reg;
	logic [2:0]  user_sync_reg;

	logic        dly_busy_reg;
	logic [31:0] dly_us_reg;
	logic [4:0]  dly_div_reg;
	logic        dly_fire_reg;

	exp_state_t  state_reg;
	logic [31:0] exp_us_reg;
	logic [4:0]  exp_div_reg;
	logic [31:0] ro_cnt_reg;
	logic [31:0] fr_cnt_reg;

	trig_src_t   src;
	logic        trig_on;
	logic        falling;
	logic        pulse_sel;
	logic        sel_level;
	logic        sel_prev;
	logic        start_pulse;
	logic        end_pulse;
	logic        wr_en;
	logic        us_tick;
	logic        dly_tick;
	logic        free_start;
	logic        line_edge;
	logic        exp_end;
	logic [31:0] shutter_clamped;

	function automatic logic edge_hit(input logic cur, input logic prev, input logic fall);
		edge_hit = fall ? (prev & ~cur) : (cur & ~prev);
	endfunction

	function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		for (int i = 0; i < 4; i++)
		begin
			merge_sel[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	assign trig_on   = ctrl_reg[CTRL_TRIG_ON];
	assign falling   = ctrl_reg[CTRL_FALLING];
	assign src       = trig_src_t'(ctrl_reg[CTRL_SRC_LSB +: 3]);
	// pulse mode only when the source is an outside trigger
	assign pulse_sel = trig_on && ctrl_reg[CTRL_PULSE]
		&& (src == SRC_LINK || src == SRC_LINE);
	assign wr_en     = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !ack_reg;
	assign us_tick   = (exp_div_reg == 5'(CYC_PER_US - 1));
	assign dly_tick  = (dly_div_reg == 5'(CYC_PER_US - 1));

	assign shutter_clamped = (shutter_reg < SHUTTER_MIN_US) ? SHUTTER_MIN_US :
		(shutter_reg > SHUTTER_MAX_US) ? SHUTTER_MAX_US : shutter_reg;

	// synchronisers; stage one feeds only stage two
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			line_sync_reg <= 3'b000;
			link_sync_reg <= 3'b000;
			user_sync_reg <= 3'b000;
		end
		else
		begin
			line_sync_reg <= {line_sync_reg[1:0], hardware_input_line_i};
			link_sync_reg <= {link_sync_reg[1:0], host_link_strobe_i};
			user_sync_reg <= {user_sync_reg[1:0], user_driven_output_bit_i};
		end
	end

	always_comb
	begin
		case (src)
			SRC_LINE:     {sel_level, sel_prev} = {line_sync_reg[1], line_sync_reg[2]};
			SRC_LINK:     {sel_level, sel_prev} = {link_sync_reg[1], link_sync_reg[2]};
			SRC_USER_OUT: {sel_level, sel_prev} = {user_sync_reg[1], user_sync_reg[2]};
			default:      {sel_level, sel_prev} = 2'b00;
		endcase
	end

	assign line_edge  = edge_hit(line_sync_reg[1], line_sync_reg[2], falling);
	assign free_start = !trig_on && running_reg && (fr_cnt_reg == 32'h0000_0000);

	always_comb
	begin
		case (src)
			SRC_SOFTWARE: start_pulse = soft_trig_reg;
			SRC_DELAY:    start_pulse = dly_fire_reg;
			default:      start_pulse = edge_hit(sel_level, sel_prev, falling);
		endcase
		if (!trig_on)
			start_pulse = free_start;
		else if (!running_reg)
			start_pulse = 1'b0;
	end

	// pulse end is the opposite edge of the start edge
	assign end_pulse = edge_hit(sel_level, sel_prev, !falling);
	assign exp_end   = (state_reg == EXP_TIMED && us_tick && exp_us_reg <= 32'h0000_0001)
		|| (state_reg == EXP_PULSE && !trig_on)
		|| (state_reg == EXP_PULSE && end_pulse && offset_reg == 32'h0000_0000);

	// delay counter armed by a line edge, counts microseconds
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dly_busy_reg <= 1'b0;
			dly_us_reg   <= 32'h0000_0000;
			dly_div_reg  <= 5'h00;
			dly_fire_reg <= 1'b0;
		end
		else
		begin
			dly_fire_reg <= 1'b0;
			if (!dly_busy_reg)
			begin
				dly_div_reg <= 5'h00;
				if (ctrl_reg[CTRL_DLY_SRC] && running_reg && line_edge)
				begin
					dly_us_reg   <= delay_reg;
					dly_fire_reg <= (delay_reg == 32'h0000_0000);
					dly_busy_reg <= (delay_reg != 32'h0000_0000);
				end
			end
			else
			begin
				dly_div_reg <= dly_tick ? 5'h00 : dly_div_reg + 5'h01;
				if (dly_tick)
				begin
					dly_us_reg <= dly_us_reg - 32'h0000_0001;
					if (dly_us_reg == 32'h0000_0001)
					begin
						dly_busy_reg <= 1'b0;
						dly_fire_reg <= 1'b1;
					end
				end
			end
		end
	end

	// exposure sequencer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg   <= EXP_WAIT;
			exp_us_reg  <= 32'h0000_0000;
			exp_div_reg <= 5'h00;
		end
		else
		begin
			case (state_reg)
				EXP_WAIT:
				begin
					exp_div_reg <= 5'h00;
					if (start_pulse)
					begin
						exp_us_reg <= shutter_clamped + offset_reg;
						state_reg  <= pulse_sel ? EXP_PULSE : EXP_TIMED;
					end
				end
				EXP_TIMED:
				begin
					// further starts are not looked at here
					exp_div_reg <= us_tick ? 5'h00 : exp_div_reg + 5'h01;
					if (us_tick)
					begin
						exp_us_reg <= exp_us_reg - 32'h0000_0001;
						if (exp_us_reg <= 32'h0000_0001)
						begin
							state_reg <= EXP_WAIT;
						end
					end
				end
				EXP_PULSE:
				begin
					// no cap on length; the offset runs on after the closing edge
					if (exp_end)
					begin
						state_reg <= EXP_WAIT;
					end
					else if (end_pulse)
					begin
						exp_us_reg <= offset_reg;
						state_reg  <= EXP_TIMED;
					end
				end
				default: state_reg <= EXP_WAIT;
			endcase
		end
	end

	assign shutter_open_o = (state_reg != EXP_WAIT);
	assign frame_start_o  = (state_reg == EXP_WAIT) && start_pulse;

	// readout model and free-run period; readout restarts at exposure end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ro_cnt_reg <= 32'h0000_0000;
			fr_cnt_reg <= 32'h0000_0000;
			frames_reg <= 32'h0000_0000;
		end
		else
		begin
			if (shutter_open_o && !exp_end)
			begin
				ro_cnt_reg <= ro_cnt_reg - ((ro_cnt_reg != 0) ? 32'h0000_0001 : 32'h0000_0000);
			end
			else if (shutter_open_o)
			begin
				ro_cnt_reg <= readout_reg;
				frames_reg <= frames_reg + 32'h0000_0001;
			end
			else if (ro_cnt_reg != 32'h0000_0000)
			begin
				ro_cnt_reg <= ro_cnt_reg - 32'h0000_0001;
			end
			fr_cnt_reg <= (!running_reg || trig_on || fr_cnt_reg == 32'h0000_0000)
				? ((running_reg && !trig_on) ? frper_reg : 32'h0000_0000)
				: fr_cnt_reg - 32'h0000_0001;
		end
	end

	assign readout_busy_o = (ro_cnt_reg != 32'h0000_0000);

	// register file
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_reg    <= CTRL_RESET;
			shutter_reg <= SHUTTER_RESET;
			offset_reg  <= 32'h0000_0000;
			delay_reg   <= 32'h0000_0000;
			frper_reg   <= FRPER_RESET;
			readout_reg <= READOUT_RESET;
		end
		else if (wr_en)
		begin
			case (wb_req_i.adr)
				OFS_CTRL:    ctrl_reg    <= merge_sel(ctrl_reg, wb_req_i.dat, wb_req_i.sel);
				OFS_SHUTTER: shutter_reg <= merge_sel(shutter_reg, wb_req_i.dat, wb_req_i.sel);
				OFS_OFFSET:  offset_reg  <= merge_sel(offset_reg, wb_req_i.dat, wb_req_i.sel);
				OFS_DELAY:   delay_reg   <= merge_sel(delay_reg, wb_req_i.dat, wb_req_i.sel);
				OFS_FRPER:   frper_reg   <= merge_sel(frper_reg, wb_req_i.dat, wb_req_i.sel);
				OFS_READOUT: readout_reg <= merge_sel(readout_reg, wb_req_i.dat, wb_req_i.sel);
				default:     ctrl_reg    <= ctrl_reg;
			endcase
		end
	end

	// commands: run and halt, one-cycle software trigger
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			running_reg   <= 1'b0;
			soft_trig_reg <= 1'b0;
		end
		else
		begin
			soft_trig_reg <= 1'b0;
			if (wr_en && wb_req_i.adr == OFS_CMD && wb_req_i.sel[0])
			begin
				if (wb_req_i.dat[CMD_HALT])
					running_reg <= 1'b0;
				else if (wb_req_i.dat[CMD_RUN])
					running_reg <= 1'b1;
				soft_trig_reg <= wb_req_i.dat[CMD_SOFT_TRIG];
			end
		end
	end

	// bus answer: registered ack the cycle after the request, ack dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= wb_req_i.cyc && wb_req_i.stb && !ack_reg;
			case (wb_req_i.adr)
				OFS_CTRL:    rdat_reg <= ctrl_reg;
				OFS_SHUTTER: rdat_reg <= shutter_reg;
				OFS_OFFSET:  rdat_reg <= offset_reg;
				OFS_DELAY:   rdat_reg <= delay_reg;
				OFS_STATUS:  rdat_reg <= {frames_reg[23:0], 3'b000, dly_busy_reg,
					readout_busy_o, running_reg, state_reg};
				OFS_FRPER:   rdat_reg <= frper_reg;
				OFS_READOUT: rdat_reg <= readout_reg;
				default:     rdat_reg <= BAD_ADDR_DATA;
			endcase
		end
	end

	assign wb_rsp_o.ack = ack_reg;
	assign wb_rsp_o.dat = rdat_reg;

endmodule

`default_nettype wire

// ===== bench/exp_trig_assertions.sv
// checker for the exposure trigger control ports
// assumes one clock and the synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module exp_trig_assertions
(
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire exp_trig_pkg::wb_req_t wb_req_i,
	input wire exp_trig_pkg::wb_rsp_t wb_rsp_o,
	input wire logic                  hardware_input_line_i,
	input wire logic                  host_link_strobe_i,
	input wire logic                  user_driven_output_bit_i,
	input wire logic                  shutter_open_o,
	input wire logic                  readout_busy_o,
	input wire logic                  frame_start_o
);
	import exp_trig_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
	endsequence
	sequence s_start;
		frame_start_o ##1 shutter_open_o;
	endsequence
	a_start_opens: assert property (frame_start_o |-> s_start)
		else $error("exposure did not open after start");
	a_open_cause: assert property ($rose(shutter_open_o) |-> $past(frame_start_o))
		else $error("exposure opened without start");
	a_busy_ignores: assert property (shutter_open_o |-> !frame_start_o)
		else $error("start taken during exposure");
	a_readout_follows: assert property ($fell(shutter_open_o) |-> ##[0:1] readout_busy_o)
		else $error("readout did not follow exposure");
	a_ack_answer: assert property (s_req |=> wb_rsp_o.ack)
		else $error("bus request not acked");
	a_ack_single: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(wb_rsp_o.ack) |-> $past(wb_req_i.cyc && wb_req_i.stb))
		else $error("ack without request");
	a_unmapped_zero: assert property (wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr >= 8'h20
		|-> wb_rsp_o.dat == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_reset_clear: assert property ($fell(rst_i) |-> !shutter_open_o && !readout_busy_o)
		else $error("outputs active after reset");
endmodule
bind exposure_trigger_control exp_trig_assertions chk_u
(
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_req_i(wb_req_i),
	.wb_rsp_o(wb_rsp_o),
	.hardware_input_line_i(hardware_input_line_i),
	.host_link_strobe_i(host_link_strobe_i),
	.user_driven_output_bit_i(user_driven_output_bit_i),
	.shutter_open_o(shutter_open_o),
	.readout_busy_o(readout_busy_o),
	.frame_start_o(frame_start_o)
);
`default_nettype wire

// ===== bench/trig_source_model.sv
// external trigger source on the hardware input line
// assumes the bench calls pulse() from a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module trig_source_model
(
	input  wire logic clk_i,
	output var  logic line_o
);
	initial line_o = 1'b0;
	// idle level, then w cycles active; callers may place the next pulse inside an exposure or a readout
	task automatic pulse(input logic fall, input int w);
		@(posedge clk_i) line_o <= fall;
		repeat (4) @(posedge clk_i);
		line_o <= ~fall;
		repeat (w) @(posedge clk_i);
		line_o <= fall;
	endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the exposure trigger control block
// assumes a one-cycle wishbone ack and a 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import exp_trig_pkg::*;
	logic    clk_i = 1'b0;
	logic    rst_i = 1'b1;
	wb_req_t req   = '0;
	wb_rsp_t rsp;
	logic    link  = 1'b0;
	logic    user  = 1'b0;
	logic    line;
	logic    open;
	logic    busy;
	logic    fs;
	int      err_count = 0;
	int      samples_checked = 0;
	int      starts = 0;
	always #25 clk_i = ~clk_i;
	// sampled mid-cycle, where the combinational start pulse has settled
	always @(negedge clk_i) if (fs === 1'b1) starts++;
	exposure_trigger_control dut_u
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_req_i(req),
		.wb_rsp_o(rsp),
		.hardware_input_line_i(line),
		.host_link_strobe_i(link),
		.user_driven_output_bit_i(user),
		.shutter_open_o(open),
		.readout_busy_o(busy),
		.frame_start_o(fs)
	);
	trig_source_model src (.clk_i(clk_i), .line_o(line));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		req <= '{1'b1, 1'b1, we, 4'hF, a, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (rsp.ack !== 1'b1 && n < 20);
		chk("ack", 32'h0000_0001, 32'(rsp.ack));
		q = rsp.dat;
		req <= '0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, q);
		chk(n, e, q);
	endtask
	task automatic run(input logic dly, input logic [2:0] s, input logic p, input logic f,
		input logic on);
		wr(OFS_CTRL, {24'h00_0000, dly, s, 1'b0, p, f, on});
		wr(OFS_CMD, 32'h0000_0001);
	endtask
	task automatic expo(output int lat, output int w, output logic rb);
		lat = 0;
		w = 0;
		@(negedge clk_i);
		while (open !== 1'b1 && lat < 3000)
		begin
			@(negedge clk_i);
			lat++;
		end
		rb = busy;
		while (open === 1'b1 && w < 3000)
		begin
			@(negedge clk_i);
			w++;
		end
		@(posedge clk_i);
	endtask
	task automatic t_regs;
		rd(OFS_CTRL, CTRL_RESET, "ctrl");
		rd(OFS_SHUTTER, SHUTTER_RESET, "shutter");
		rd(OFS_FRPER, FRPER_RESET, "frper");
		rd(OFS_READOUT, READOUT_RESET, "readout");
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, BAD_ADDR_DATA, "unmapped");
	endtask
	task automatic t_timed(input logic f, input logic [31:0] sh);
		int l, w, s0;
		logic rb;
		wr(OFS_SHUTTER, sh);
		wr(OFS_OFFSET, 32'h0000_0001);
		wr(OFS_READOUT, 32'h0000_0014);
		run(1'b0, SRC_LINE, 1'b0, f, 1'b1);
		s0 = starts;
		fork
			begin
				src.pulse(f, 5);
				repeat (20) @(posedge clk_i);
				src.pulse(f, 5);
			end
			expo(l, w, rb);
		join
		chk("timed width", ((sh < 4 ? 32'h0000_0004 : sh) + 1) * 20, 32'(w));
		chk("starts", 32'h0000_0001, 32'(starts - s0));
		chk("readout", 32'h0000_0001, 32'(busy));
	endtask
	task automatic t_pulse(input logic f);
		int l, w;
		logic rb;
		wr(OFS_READOUT, 32'h0000_012C);
		run(1'b0, SRC_LINE, 1'b1, f, 1'b1);
		fork
			begin
				src.pulse(f, 400);
				// the offset of 1 us keeps the shutter open 20 cycles past the closing edge
				repeat (30) @(posedge clk_i);
				src.pulse(f, 400);
			end
			begin
				expo(l, w, rb);
				chk("pulse width", 32'h0000_0001, 32'(w inside {[419:421]}));
				expo(l, w, rb);
				chk("overlap", 32'h0000_0001, 32'(rb));
			end
		join
	endtask
	task automatic t_delay;
		int l, w;
		logic rb;
		wr(OFS_DELAY, 32'h0000_0002);
		run(1'b1, SRC_DELAY, 1'b0, 1'b0, 1'b1);
		fork
			src.pulse(1'b0, 5);
			expo(l, w, rb);
		join
		chk("delay", 32'h0000_0001, 32'(l inside {[44:54]}));
	endtask
	task automatic t_src;
		int l, w;
		logic rb;
		for (int s = 0; s < 3; s++)
		begin
			run(1'b0, 3'(s), 1'b0, 1'b0, 1'b1);
			fork
				begin
					if (s == 0) wr(OFS_CMD, 32'h0000_0004);
					if (s == 1) user <= 1'b1;
					if (s == 2) link <= 1'b1;
					repeat (5) @(posedge clk_i);
					user <= 1'b0;
					link <= 1'b0;
				end
				expo(l, w, rb);
			join
			chk("source width", 32'h0000_0078, 32'(w));
		end
	endtask
	task automatic t_free;
		int s0;
		wr(OFS_FRPER, 32'h0000_0190);
		run(1'b0, SRC_SOFTWARE, 1'b0, 1'b0, 1'b0);
		s0 = starts;
		repeat (2000) @(posedge clk_i);
		chk("free run", 32'h0000_0001, 32'((starts - s0) inside {[4:6]}));
		wr(OFS_CMD, 32'h0000_0002);
		repeat (200) @(posedge clk_i);
		s0 = starts;
		repeat (1000) @(posedge clk_i);
		chk("halted", 32'h0000_0000, 32'(starts - s0));
	endtask
	task automatic print_verdict;
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		print_verdict();
	end
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_timed(1'b1, 32'h0000_0002);
		t_pulse(1'b0);
		t_timed(1'b0, 32'h0000_0005);
		t_pulse(1'b1);
		t_delay();
		t_src();
		t_free();
		print_verdict();
	end
endmodule
`default_nettype wire
